/* core/jlcr_pkg.sv */
// Constants for the serial link configuration register bank
package jlcr_pkg;
    // Register indices; byte address is four times the index
    localparam logic [6:0] IDX_PREEMPH = 7'h4d;
    localparam logic [6:0] IDX_REGULATOR = 7'h50;
    localparam logic [6:0] IDX_IDENT = 7'h51;
    localparam logic [6:0] IDX_SCRAMBLE = 7'h52;
    localparam logic [6:0] IDX_MFLEN = 7'h53;
    localparam logic [6:0] IDX_VERSION = 7'h55;
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_PREEMPH = {3'h0, IDX_PREEMPH, 2'h0};
    localparam logic [11:0] ADDR_REGULATOR = {3'h0, IDX_REGULATOR, 2'h0};
    localparam logic [11:0] ADDR_IDENT = {3'h0, IDX_IDENT, 2'h0};
    localparam logic [11:0] ADDR_SCRAMBLE = {3'h0, IDX_SCRAMBLE, 2'h0};
    localparam logic [11:0] ADDR_MFLEN = {3'h0, IDX_MFLEN, 2'h0};
    localparam logic [11:0] ADDR_VERSION = {3'h0, IDX_VERSION, 2'h0};
    // Field positions (low bit of each field)
    localparam int POS_STRENGTH = 4;
    localparam int POS_REG_BOOST = 1;
    localparam int POS_PART = 8;
    localparam int POS_BANK = 0;
    localparam int POS_SCRAMBLE = 7;
    localparam int POS_MFLEN = 0;
    localparam int POS_SUBCLASS = 13;
    localparam int POS_REVISION = 5;
    // Values after reset
    localparam logic [3:0] RST_STRENGTH = 4'h0;
    localparam logic RST_REG_BOOST = 1'b0;
    localparam logic [7:0] RST_PART = 8'h00;
    localparam logic [4:0] RST_BANK = 5'h00;
    localparam logic RST_SCRAMBLE = 1'b0;
    localparam logic [4:0] RST_MFLEN = 5'h00;
    localparam logic [2:0] RST_SUBCLASS = 3'h0;
    localparam logic [2:0] RST_REVISION = 3'h0;
    // Link revision and subclass codes
    localparam logic [2:0] REV_A = 3'h0;
    localparam logic [2:0] REV_B = 3'h1;
    localparam logic [2:0] SUBCLASS_0 = 3'h0;
    localparam logic [2:0] SUBCLASS_1 = 3'h1;
    localparam logic [2:0] SUBCLASS_2 = 3'h2;
    // Pre-emphasis current step in microamps
    localparam int STEP_UA = 250;
    localparam logic [11:0] STEP_UA_W = 12'(STEP_UA);
endpackage

/* core/jlcr_config_regs.sv */
// Serial link configuration register bank with an APB slave port
//
// Summary of operation
// [RL1] Extra pre-emphasis current is strength code times a quarter milliamp.
// [RL2] A strength code of zero means no pre-emphasis at all.
// [RL3] Regulator boost: clear gives default level, set gives raised level.
// [RL4] Upper byte of the identifier register forces the part number field.
// [RL5] Low five bits of the identifier register force the bank number.
// [RL6] Scrambler bit turns lane scrambling off when clear, on when set.
// [RL7] Multiframe length minus one, applied only while its force bit is set.
// [RL8] Subclass codes 000, 001, 010 select subclass 0, 1, 2.
// [RL9] Revision code 000 selects revision A, 001 selects revision B.
// [RL10] Fields act only with override enable; else revision B, subclass 1.
// [RL11] Software writes zero to unused bits; all fields reset to zero.
`timescale 1ns/10ps
module jlcr_config_regs
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [jlcr_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Force bits held elsewhere in the register map
    input wire logic multiframe_force,
    input wire logic revision_override_enable,
    // Lane driver
    output logic [3:0] driver_boost_strength,
    output logic [11:0] preemph_current_ua,
    output logic preemph_active,
    // Link PLL regulator
    output logic link_pll_regulator_boost,
    // Link configuration fields
    output logic [7:0] forced_part_number_field,
    output logic [4:0] forced_bank_number_field,
    output logic scrambler_on,
    output logic [4:0] forced_multiframe_length,
    output logic multiframe_force_active,
    output logic [5:0] frames_per_multiframe,
    output logic [2:0] link_subclass_select,
    output logic [2:0] link_revision_select,
    output logic [2:0] active_subclass,
    output logic [2:0] active_revision,
    output logic active_config_invalid
);

    typedef struct packed {
        logic [3:0] strength;
        logic reg_boost;
        logic [7:0] part;
        logic [4:0] bank;
        logic scramble;
        logic [4:0] mflen;
        logic [2:0] subclass;
        logic [2:0] revision;
        logic [11:0] current_ua;
        logic preemph_on;
        logic mf_active;
        logic [5:0] mf_frames;
        logic [2:0] act_sub;
        logic [2:0] act_rev;
        logic act_bad;
        logic [15:0] rdata;
        logic err;
    } jlcr_state_s;

    localparam jlcr_state_s RESET_STATE = '{
        strength: jlcr_pkg::RST_STRENGTH,
        reg_boost: jlcr_pkg::RST_REG_BOOST,
        part: jlcr_pkg::RST_PART,
        bank: jlcr_pkg::RST_BANK,
        scramble: jlcr_pkg::RST_SCRAMBLE,
        mflen: jlcr_pkg::RST_MFLEN,
        subclass: jlcr_pkg::RST_SUBCLASS,
        revision: jlcr_pkg::RST_REVISION,
        current_ua: 12'h000,
        preemph_on: 1'b0,
        mf_active: 1'b0,
        mf_frames: 6'h00,
        act_sub: jlcr_pkg::SUBCLASS_1,
        act_rev: jlcr_pkg::REV_B,
        act_bad: 1'b0,
        rdata: 16'h0000,
        err: 1'b0
    };

    jlcr_state_s state_q;
    jlcr_state_s state_d;

    logic setup_phase;
    logic access_phase;
    logic wr_en;
    logic lo_lane;
    logic hi_lane;

    assign setup_phase = psel & ~penable;
    assign access_phase = psel & penable;
    // Write lands on the access edge of a mapped, aligned address
    assign wr_en = access_phase & pwrite & ~state_q.err;
    assign lo_lane = pstrb[0];
    assign hi_lane = pstrb[1];

    always_comb
    begin
        state_d = state_q;
        // Address decode and read data capture in the setup cycle
        if (setup_phase)
        begin
            state_d.err = 1'b0;
            state_d.rdata = 16'h0000;
            case (paddr)
                jlcr_pkg::ADDR_PREEMPH:
                    state_d.rdata[jlcr_pkg::POS_STRENGTH +: 4] =
                        state_q.strength;
                jlcr_pkg::ADDR_REGULATOR:
                    state_d.rdata[jlcr_pkg::POS_REG_BOOST] =
                        state_q.reg_boost;
                jlcr_pkg::ADDR_IDENT:
                begin
                    state_d.rdata[jlcr_pkg::POS_PART +: 8] = state_q.part;
                    state_d.rdata[jlcr_pkg::POS_BANK +: 5] = state_q.bank;
                end
                jlcr_pkg::ADDR_SCRAMBLE:
                    state_d.rdata[jlcr_pkg::POS_SCRAMBLE] = state_q.scramble;
                jlcr_pkg::ADDR_MFLEN:
                    state_d.rdata[jlcr_pkg::POS_MFLEN +: 5] = state_q.mflen;
                jlcr_pkg::ADDR_VERSION:
                begin
                    state_d.rdata[jlcr_pkg::POS_SUBCLASS +: 3] =
                        state_q.subclass;
                    state_d.rdata[jlcr_pkg::POS_REVISION +: 3] =
                        state_q.revision;
                end
                default:
                    state_d.err = 1'b1;
            endcase
        end
        // Unused bit positions are not stored and read back as zero
        if (wr_en)
        begin
            case (paddr)
                jlcr_pkg::ADDR_PREEMPH:
                    if (lo_lane)
                        state_d.strength =
                            pwdata[jlcr_pkg::POS_STRENGTH +: 4]; // RL1
                jlcr_pkg::ADDR_REGULATOR:
                    if (lo_lane)
                        state_d.reg_boost =
                            pwdata[jlcr_pkg::POS_REG_BOOST]; // RL3
                jlcr_pkg::ADDR_IDENT:
                begin
                    if (hi_lane)
                        state_d.part = pwdata[jlcr_pkg::POS_PART +: 8]; // RL4
                    if (lo_lane)
                        state_d.bank = pwdata[jlcr_pkg::POS_BANK +: 5]; // RL5
                end
                jlcr_pkg::ADDR_SCRAMBLE:
                    if (lo_lane)
                        state_d.scramble =
                            pwdata[jlcr_pkg::POS_SCRAMBLE]; // RL6
                jlcr_pkg::ADDR_MFLEN:
                    if (lo_lane)
                        state_d.mflen =
                            pwdata[jlcr_pkg::POS_MFLEN +: 5]; // RL7
                jlcr_pkg::ADDR_VERSION:
                begin
                    if (hi_lane)
                        state_d.subclass =
                            pwdata[jlcr_pkg::POS_SUBCLASS +: 3]; // RL8
                    if (lo_lane)
                        state_d.revision =
                            pwdata[jlcr_pkg::POS_REVISION +: 3]; // RL9
                end
                default:
                    state_d.err = state_q.err;
            endcase
        end
        // Derived link settings follow the new field values
        state_d.current_ua =
            12'(state_d.strength) * jlcr_pkg::STEP_UA_W; // RL1
        state_d.preemph_on = (state_d.strength != 4'h0); // RL2
        state_d.mf_active = multiframe_force; // RL7
        state_d.mf_frames = multiframe_force ?
            6'({1'b0, state_d.mflen} + 6'h01) : 6'h00; // RL7
        if (revision_override_enable)
        begin
            state_d.act_sub = state_d.subclass; // RL8
            state_d.act_rev = state_d.revision; // RL9
        end
        else
        begin
            state_d.act_sub = jlcr_pkg::SUBCLASS_1; // RL10
            state_d.act_rev = jlcr_pkg::REV_B; // RL10
        end
        state_d.act_bad = (state_d.act_sub > jlcr_pkg::SUBCLASS_2) ||
            (state_d.act_rev > jlcr_pkg::REV_B);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_q <= RESET_STATE; // RL11
        else
            state_q <= state_d;
    end

    // Zero-wait slave: every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = access_phase & state_q.err;
    assign prdata = {16'h0000, state_q.rdata};

    assign driver_boost_strength = state_q.strength;
    assign preemph_current_ua = state_q.current_ua;
    assign preemph_active = state_q.preemph_on;
    assign link_pll_regulator_boost = state_q.reg_boost;
    assign forced_part_number_field = state_q.part;
    assign forced_bank_number_field = state_q.bank;
    assign scrambler_on = state_q.scramble;
    assign forced_multiframe_length = state_q.mflen;
    assign multiframe_force_active = state_q.mf_active;
    assign frames_per_multiframe = state_q.mf_frames;
    assign link_subclass_select = state_q.subclass;
    assign link_revision_select = state_q.revision;
    assign active_subclass = state_q.act_sub;
    assign active_revision = state_q.act_rev;
    assign active_config_invalid = state_q.act_bad;

    // Checks on the block's own outputs

    boost_current_a: assert property ( // RL1
        @(posedge pclk) disable iff (!presetn)
        preemph_current_ua ==
            12'(driver_boost_strength) * jlcr_pkg::STEP_UA_W)
    else $error("pre-emphasis current not strength times step");

    no_preemph_a: assert property ( // RL2
        @(posedge pclk) disable iff (!presetn)
        (driver_boost_strength == 4'h0) |->
            (!preemph_active && preemph_current_ua == 12'h000))
    else $error("pre-emphasis active with zero strength");

    regulator_boost_a: assert property ( // RL3
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == jlcr_pkg::ADDR_REGULATOR && pstrb[0]) |=>
            (link_pll_regulator_boost == $past(pwdata[1])))
    else $error("regulator boost did not follow write");

    part_number_a: assert property ( // RL4
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == jlcr_pkg::ADDR_IDENT && pstrb[1]) |=>
            (forced_part_number_field == $past(pwdata[15:8])))
    else $error("part number field did not follow write");

    bank_number_a: assert property ( // RL5
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == jlcr_pkg::ADDR_IDENT && pstrb[0]) |=>
            (forced_bank_number_field == $past(pwdata[4:0])))
    else $error("bank number field did not follow write");

    scrambler_hold_a: assert property ( // RL6
        @(posedge pclk) disable iff (!presetn)
        !(wr_en && paddr == jlcr_pkg::ADDR_SCRAMBLE) |=>
            $stable(scrambler_on))
    else $error("scrambler enable changed without a write");

    mf_apply_a: assert property ( // RL7
        @(posedge pclk) disable iff (!presetn)
        !multiframe_force ##1 !multiframe_force |->
            (!multiframe_force_active && frames_per_multiframe == 6'h00))
    else $error("multiframe length applied without force");

    mf_length_a: assert property ( // RL7
        @(posedge pclk) disable iff (!presetn)
        $past(multiframe_force) |->
            frames_per_multiframe == {1'b0, forced_multiframe_length} + 6'h01)
    else $error("frames per multiframe not length plus one");

    subclass_sel_a: assert property ( // RL8
        @(posedge pclk) disable iff (!presetn)
        $past(revision_override_enable) && $stable(link_subclass_select)
            |-> active_subclass == link_subclass_select)
    else $error("subclass not taken from its field");

    revision_sel_a: assert property ( // RL9
        @(posedge pclk) disable iff (!presetn)
        $past(revision_override_enable) && $stable(link_revision_select)
            |-> active_revision == link_revision_select)
    else $error("revision not taken from its field");

    default_mode_a: assert property ( // RL10
        @(posedge pclk) disable iff (!presetn)
        !revision_override_enable |=>
            (active_revision == 3'h1 && active_subclass == 3'h1))
    else $error("default mode not revision B subclass 1");

    unmapped_err_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (setup_phase && paddr[1:0] != 2'h0) ##1 access_phase |->
            (pslverr && prdata == 32'h0000_0000))
    else $error("misaligned access not flagged");

endmodule

/* sim/jlcr_config_regs_test.sv */
// Self-checking bench for the link configuration register bank
`timescale 1ns/10ps
module jlcr_config_regs_test;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb, strength;
    logic mf_force, rev_en, pre_act, boost, scr, mf_act, bad;
    logic [11:0] cur_ua;
    logic [7:0] part;
    logic [4:0] bank, mflen;
    logic [5:0] frames;
    logic [2:0] sub_sel, rev_sel, act_sub, act_rev;
    int fails, n_compared;

    jlcr_config_regs jlcr_config_regs_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .multiframe_force(mf_force), .revision_override_enable(rev_en),
        .driver_boost_strength(strength), .preemph_current_ua(cur_ua),
        .preemph_active(pre_act), .link_pll_regulator_boost(boost),
        .forced_part_number_field(part), .forced_bank_number_field(bank),
        .scrambler_on(scr), .forced_multiframe_length(mflen),
        .multiframe_force_active(mf_act), .frames_per_multiframe(frames),
        .link_subclass_select(sub_sel), .link_revision_select(rev_sel),
        .active_subclass(act_sub), .active_revision(act_rev),
        .active_config_invalid(bad)
    );

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task wrap_up;
        if (fails == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected value at %0t: got %h, want %h", $time, got,
                exp);
        end
    endtask

    task chk_err(input logic got, input logic exp);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected slverr at %0t: got %h, want %h", $time, got,
                exp);
        end
    endtask

    task tick(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    // One APB transfer; returns with outputs of the access edge settled
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            chk_err(pready, 1'b1);
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    task rd_chk(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk_val(rd, exp);
        chk_err(err, 1'b0);
    endtask

    task t_reset;
        rd_chk(jlcr_pkg::ADDR_PREEMPH, 32'h0);
        rd_chk(jlcr_pkg::ADDR_REGULATOR, 32'h0);
        rd_chk(jlcr_pkg::ADDR_IDENT, 32'h0);
        rd_chk(jlcr_pkg::ADDR_SCRAMBLE, 32'h0);
        rd_chk(jlcr_pkg::ADDR_MFLEN, 32'h0);
        rd_chk(jlcr_pkg::ADDR_VERSION, 32'h0);
        chk_val({act_sub, act_rev, pre_act, frames}, 32'h480);
    endtask

    // Every strength code, ending on zero
    task t_preemph;
        for (int i = 15; i >= 0; i--)
        begin
            xfer(1'b1, jlcr_pkg::ADDR_PREEMPH, 32'(i) << 4);
            chk_val(32'(strength), 32'(i));
            chk_val(32'(cur_ua), 32'(i * jlcr_pkg::STEP_UA));
            chk_val(32'(pre_act), 32'(i != 0));
            rd_chk(jlcr_pkg::ADDR_PREEMPH, 32'(i) << 4);
        end
    endtask

    task t_fields;
        xfer(1'b1, jlcr_pkg::ADDR_REGULATOR, 32'h2);
        chk_val(32'(boost), 32'h1);
        xfer(1'b1, jlcr_pkg::ADDR_IDENT, 32'ha51f);
        chk_val({part, 3'h0, bank}, 32'ha51f);
        rd_chk(jlcr_pkg::ADDR_IDENT, 32'ha51f);
        xfer(1'b1, jlcr_pkg::ADDR_IDENT, 32'h5a0a);
        chk_val({part, 3'h0, bank}, 32'h5a0a);
        // A cleared byte strobe leaves the fields of that lane alone
        @(posedge pclk);
        pstrb <= 4'h1;
        xfer(1'b1, jlcr_pkg::ADDR_IDENT, 32'hffff);
        chk_val({part, 3'h0, bank}, 32'h5a1f);
        @(posedge pclk);
        pstrb <= 4'h2;
        xfer(1'b1, jlcr_pkg::ADDR_IDENT, 32'h0);
        chk_val({part, 3'h0, bank}, 32'h001f);
        @(posedge pclk);
        pstrb <= 4'hf;
        xfer(1'b1, jlcr_pkg::ADDR_SCRAMBLE, 32'h80);
        chk_val(32'(scr), 32'h1);
        rd_chk(jlcr_pkg::ADDR_SCRAMBLE, 32'h80);
        xfer(1'b1, jlcr_pkg::ADDR_SCRAMBLE, 32'h0);
        chk_val(32'(scr), 32'h0);
        rd_chk(jlcr_pkg::ADDR_REGULATOR, 32'h2);
        xfer(1'b1, jlcr_pkg::ADDR_REGULATOR, 32'h0);
        chk_val(32'(boost), 32'h0);
    endtask

    task t_mflen;
        xfer(1'b1, jlcr_pkg::ADDR_MFLEN, 32'h13);
        chk_val({mflen, mf_act, frames}, {5'h13, 7'h0});
        @(posedge pclk);
        mf_force <= 1'b1;
        tick(1);
        chk_val({mflen, mf_act, frames}, {5'h13, 7'h54});
        xfer(1'b1, jlcr_pkg::ADDR_MFLEN, 32'h1f);
        chk_val(32'(frames), 32'h20);
        @(posedge pclk);
        mf_force <= 1'b0;
        tick(1);
        chk_val({mf_act, frames}, 32'h0);
    endtask

    // Subclass codes 0 to 3 and revision codes 0 to 2, with and without the override
    task t_version;
        for (int s = 0; s < 4; s++)
            for (int r = 0; r < 3; r++)
            begin
                xfer(1'b1, jlcr_pkg::ADDR_VERSION, 32'((s << 13) | (r << 5)));
                chk_val({sub_sel, rev_sel}, 32'((s << 3) | r));
                chk_val({act_sub, act_rev, bad}, 32'h12);
                @(posedge pclk);
                rev_en <= 1'b1;
                tick(1);
                chk_val({act_sub, act_rev}, 32'((s << 3) | r));
                chk_val(32'(bad), 32'(s > 2 || r > 1));
                @(posedge pclk);
                rev_en <= 1'b0;
                tick(1);
                chk_val({act_sub, act_rev}, 32'h9);
                rd_chk(jlcr_pkg::ADDR_VERSION, 32'((s << 13) | (r << 5)));
            end
    endtask

    task t_unmapped;
        xfer(1'b1, jlcr_pkg::ADDR_PREEMPH, 32'h50);
        xfer(1'b1, 12'h138, 32'hffff);
        chk_err(err, 1'b1);
        xfer(1'b1, 12'h135, 32'h0);
        chk_err(err, 1'b1);
        xfer(1'b0, 12'h138, 32'h0);
        chk_err(err, 1'b1);
        chk_val(rd, 32'h0);
        rd_chk(jlcr_pkg::ADDR_PREEMPH, 32'h50);
    endtask

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hf;
        mf_force = 1'b0;
        rev_en = 1'b0;
        fails = 0;
        n_compared = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_preemph();
        t_fields();
        t_mflen();
        t_version();
        t_unmapped();
        wrap_up();
    end
endmodule
